// *** rtl/asm_status_monitor.sv ***
// Status and monitor register bank of a two-channel switching amplifier
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/100ps

// Functional notes
// - Channel 0 frequency mode reads in bits 6:4 at 0x60
// - Channel 0 power mode reads in bits 1:0 at 0x60
// - 0x61 holds mute, core supply, stage supply, both capacitor flags in 5:1
// - Health bit 0 shows an over-current event on that channel
// - 0x62 gives channel 0 modulation index, 0..1 as 0..255
// - Channel 1 mirrors channel 0 at 0x64, 0x65, 0x66
// - Channel 1 health bits 5..0 in channel 0 order
// - 0x6D accumulates each error source until cleared
// - Error bits read 0 normally and 1 when triggered
// - Error bit order: cap OV, OC, PLL, UV, OT warn, OT err, short, DC
// - 0x7C shows live unlatched error sources
// - 0x75 bits 2:0 report output-stage configuration
// - Monitor and error registers are read-only and reset to 0x00
// - Wipe bit 2 of 0x2D: low-high-low sequence clears accumulated errors
module asm_status_monitor (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire asm_pkg::asm_bus_t BUS,
  output logic [7:0] RDATA,
  input wire asm_pkg::asm_chan_t CH0_IN,
  input wire asm_pkg::asm_chan_t CH1_IN,
  input wire asm_pkg::asm_err_t ERR_IN,
  input wire logic [2:0] OUT_CFG_IN,
  output logic IRQ
);

  // Two-flop synchronisers for all monitored levels
  localparam int MON_W = 2 * $bits(asm_pkg::asm_chan_t) + $bits(asm_pkg::asm_err_t) + 3;
  logic [MON_W-1:0] mon_meta_reg;
  logic [MON_W-1:0] mon_sync_reg;
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      mon_meta_reg <= '0;
      mon_sync_reg <= '0;
    end
    else
    begin
      mon_meta_reg <= {CH0_IN, CH1_IN, ERR_IN, OUT_CFG_IN};
      mon_sync_reg <= mon_meta_reg;
    end
  end

  asm_pkg::asm_chan_t ch0;
  asm_pkg::asm_chan_t ch1;
  asm_pkg::asm_err_t err_live;
  logic [2:0] out_cfg;
  assign {ch0, ch1, err_live, out_cfg} = mon_sync_reg;

  // Register images of each monitor
  function automatic logic [7:0] mode_byte(input asm_pkg::asm_chan_t c);
    mode_byte = {1'b0, c.mode.switch_rate_state, 2'b00, c.mode.power_level_state};
  endfunction : mode_byte

  function automatic logic [7:0] health_byte(input asm_pkg::asm_chan_t c);
    health_byte = {2'b00, c.health};
  endfunction : health_byte

  wire [7:0] ch0_mode_monitor = mode_byte(ch0);
  wire [7:0] ch1_mode_monitor = mode_byte(ch1);
  wire [7:0] ch0_health_flags = health_byte(ch0);
  wire [7:0] ch1_health_flags = health_byte(ch1);
  wire [7:0] ch0_modulation_level = ch0.modulation_level;
  wire [7:0] ch1_modulation_level = ch1.modulation_level;
  wire [7:0] error_live_flags = err_live;
  wire [7:0] output_config_monitor = {5'b00000, out_cfg};

  // Write decode
  wire wr_wipe = BUS.wr && (BUS.addr == asm_pkg::OFS_WIPE_CTRL);
  wire wr_irq_status = BUS.wr && (BUS.addr == asm_pkg::OFS_IRQ_STATUS);
  wire wr_irq_mask = BUS.wr && (BUS.addr == asm_pkg::OFS_IRQ_MASK);

  // Wipe control register and low-high-low tracker
  logic [7:0] wipe_ctrl_reg;
  logic [7:0] wipe_ctrl_next;
  logic wipe_armed_reg;
  logic wipe_armed_next;
  wire wipe_now = wipe_ctrl_reg[asm_pkg::WIPE_BIT];
  wire wipe_new = wipe_ctrl_next[asm_pkg::WIPE_BIT];
  assign wipe_ctrl_next = wr_wipe ? BUS.wdata : wipe_ctrl_reg;
  // Rising edge arms, following falling edge fires the clear
  assign wipe_armed_next = (!wipe_now && wipe_new) ? 1'b1 :
                           (wipe_now && !wipe_new) ? 1'b0 : wipe_armed_reg;
  wire fault_handler_wipe = wipe_armed_reg && wipe_now && !wipe_new;

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      wipe_ctrl_reg <= asm_pkg::WIPE_CTRL_RESET;
      wipe_armed_reg <= 1'b0;
    end
    else
    begin
      wipe_ctrl_reg <= wipe_ctrl_next;
      wipe_armed_reg <= wipe_armed_next;
    end
  end

  // Accumulated errors: a live source wins over the wipe
  logic [7:0] error_sticky_reg;
  logic [7:0] error_sticky_next;
  assign error_sticky_next = (fault_handler_wipe ? 8'h00 : error_sticky_reg) | err_live;
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
      error_sticky_reg <= asm_pkg::RESET_VAL;
    else
      error_sticky_reg <= error_sticky_next;
  end

  // Interrupt status: rising edges of live errors, write one to clear
  logic [7:0] err_prev_reg;
  logic [7:0] irq_status_reg;
  logic [7:0] irq_status_next;
  logic [7:0] irq_mask_reg;
  wire [7:0] err_rise = err_live & ~err_prev_reg;
  wire [7:0] irq_w1c = wr_irq_status ? BUS.wdata : 8'h00;
  assign irq_status_next = (irq_status_reg & ~irq_w1c) | err_rise;
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      err_prev_reg <= '0;
      irq_status_reg <= '0;
      irq_mask_reg <= '0;
    end
    else
    begin
      err_prev_reg <= err_live;
      irq_status_reg <= irq_status_next;
      irq_mask_reg <= wr_irq_mask ? BUS.wdata : irq_mask_reg;
    end
  end
  assign IRQ = |(irq_status_reg & irq_mask_reg);

  // Read mux, unmapped addresses read zero
  logic [7:0] rd_mux;
  always_comb
  begin
    unique case (BUS.addr)
      asm_pkg::OFS_CH0_MODE: rd_mux = ch0_mode_monitor;
      asm_pkg::OFS_CH0_HEALTH: rd_mux = ch0_health_flags;
      asm_pkg::OFS_CH0_MOD: rd_mux = ch0_modulation_level;
      asm_pkg::OFS_CH1_MODE: rd_mux = ch1_mode_monitor;
      asm_pkg::OFS_CH1_HEALTH: rd_mux = ch1_health_flags;
      asm_pkg::OFS_CH1_MOD: rd_mux = ch1_modulation_level;
      asm_pkg::OFS_ERR_STICKY: rd_mux = error_sticky_reg;
      asm_pkg::OFS_OUT_CFG: rd_mux = output_config_monitor;
      asm_pkg::OFS_ERR_LIVE: rd_mux = error_live_flags;
      asm_pkg::OFS_WIPE_CTRL: rd_mux = wipe_ctrl_reg;
      asm_pkg::OFS_IRQ_STATUS: rd_mux = irq_status_reg;
      asm_pkg::OFS_IRQ_MASK: rd_mux = irq_mask_reg;
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data stands one cycle after the strobe
  logic [7:0] rdata_reg;
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
      rdata_reg <= asm_pkg::RESET_VAL;
    else
      rdata_reg <= BUS.rd ? rd_mux : 8'h00;
  end
  assign RDATA = rdata_reg;

  // Assertions
  a_sticky_holds: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    !fault_handler_wipe |=> (error_sticky_reg & $past(error_sticky_reg)) == $past(error_sticky_reg))
    else $error("sticky error bit dropped without wipe");
  a_sticky_catches: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    ((error_sticky_reg & err_live) == err_live) || $changed(err_live))
    else $error("live error not accumulated");
  a_wipe_clears: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    fault_handler_wipe |=> error_sticky_reg == $past(err_live))
    else $error("wipe did not clear accumulated errors");
  sequence s_wipe_high;
    wr_wipe && BUS.wdata[asm_pkg::WIPE_BIT] && !wipe_now;
  endsequence
  a_wipe_arms: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    s_wipe_high |=> wipe_armed_reg)
    else $error("rising wipe bit did not arm");
  a_read_mode: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    BUS.rd && BUS.addr == asm_pkg::OFS_CH0_MODE |=> RDATA[6:4] == $past(ch0.mode.switch_rate_state))
    else $error("channel 0 frequency mode misread");
  a_read_health: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    BUS.rd && BUS.addr == asm_pkg::OFS_CH1_HEALTH |=> RDATA == {2'b00, $past(ch1.health)})
    else $error("channel 1 health misread");
  a_read_live: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    BUS.rd && BUS.addr == asm_pkg::OFS_ERR_LIVE |=> RDATA == $past(err_live))
    else $error("live error misread");
  a_read_cfg: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    BUS.rd && BUS.addr == asm_pkg::OFS_OUT_CFG |=> RDATA[7:3] == 5'b00000)
    else $error("output config upper bits not zero");
  a_read_noside: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    BUS.rd && !fault_handler_wipe |=> (error_sticky_reg & $past(error_sticky_reg)) == $past(error_sticky_reg))
    else $error("read disturbed accumulated errors");
  a_ro_write: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    BUS.wr && BUS.addr == asm_pkg::OFS_ERR_STICKY && !fault_handler_wipe && err_live == 8'h00
      |=> error_sticky_reg == $past(error_sticky_reg))
    else $error("write changed read-only register");

endmodule : asm_status_monitor

// *** rtl/asm_pkg.sv ***
// Package: register map, field layouts and carrier types of the amplifier status monitor
package asm_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  // Register offsets
  localparam logic [7:0] OFS_CH0_MODE = 8'h60;
  localparam logic [7:0] OFS_CH0_HEALTH = 8'h61;
  localparam logic [7:0] OFS_CH0_MOD = 8'h62;
  localparam logic [7:0] OFS_CH1_MODE = 8'h64;
  localparam logic [7:0] OFS_CH1_HEALTH = 8'h65;
  localparam logic [7:0] OFS_CH1_MOD = 8'h66;
  localparam logic [7:0] OFS_ERR_STICKY = 8'h6d;
  localparam logic [7:0] OFS_OUT_CFG = 8'h75;
  localparam logic [7:0] OFS_ERR_LIVE = 8'h7c;
  localparam logic [7:0] OFS_WIPE_CTRL = 8'h2d;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h80;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h81;
  // Field position and reset values
  localparam int WIPE_BIT = 2;
  localparam logic [7:0] RESET_VAL = 8'h00;
  localparam logic [7:0] WIPE_CTRL_RESET = 8'h30;
  // Frequency mode in 6:4, power mode in 1:0
  typedef struct packed {
    logic [2:0] switch_rate_state;
    logic [1:0] power_level_state;
  } asm_mode_t;
  // Health flags, bit 5 down to 0
  typedef struct packed {
    logic silenced_flag;
    logic core_supply_good;
    logic stage_supply_good;
    logic second_cap_good;
    logic first_cap_good;
    logic overcurrent_flag;
  } asm_health_t;
  // Per-channel monitor bundle
  typedef struct packed {
    asm_mode_t mode;
    asm_health_t health;
    logic [7:0] modulation_level;
  } asm_chan_t;
  // Error vector bits 7..0
  typedef struct packed {
    logic dc_fault;
    logic pin_short;
    logic temp_error;
    logic temp_warning;
    logic stage_undervolt;
    logic pll_error;
    logic overcurrent;
    logic cap_overvolt;
  } asm_err_t;
  // Register bus request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } asm_bus_t;
endpackage : asm_pkg

// *** sim/amp_status_monitor_regs_tb.sv ***
// Self-checking testbench of the amplifier status monitor register bank
`timescale 1ns/100ps
module amp_status_monitor_regs_tb;
  typedef struct packed {
    asm_pkg::asm_chan_t c0;
    asm_pkg::asm_chan_t c1;
    asm_pkg::asm_err_t err;
    logic [2:0] cfg;
  } asm_row_t;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  asm_pkg::asm_bus_t bus = '0;
  asm_pkg::asm_chan_t ch0 = '0;
  asm_pkg::asm_chan_t ch1 = '0;
  asm_pkg::asm_err_t err = '0;
  logic [2:0] cfg = 3'h0;
  logic [7:0] rdata;
  logic irq;
  int failures = 0;
  int n_checks = 0;
  logic [7:0] acc = 8'h00;
  asm_row_t rows [4];
  logic [7:0] ro_ofs [9] = '{8'h60, 8'h61, 8'h62, 8'h64, 8'h65, 8'h66, 8'h6d, 8'h75, 8'h7c};
  // Clock at 250 MHz
  always #2 sys_clk = ~sys_clk;
  asm_status_monitor dut_u (.SYS_CLK(sys_clk), .RST_N(rst_n), .BUS(bus), .RDATA(rdata),
    .CH0_IN(ch0), .CH1_IN(ch1), .ERR_IN(err), .OUT_CFG_IN(cfg), .IRQ(irq));
  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus <= {a, d, 2'b10};
    @(posedge sys_clk);
    bus <= '0;
  endtask : wr
  // One-cycle read strobe, data checked in the following cycle
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    bus <= {a, 8'h00, 2'b01};
    @(posedge sys_clk);
    bus <= '0;
    #1;
    chk(rdata, e);
  endtask : rd
  // Three monitor registers of one channel
  task automatic rd_chan(input logic [7:0] b, input asm_pkg::asm_chan_t c);
    rd(b, {1'b0, c.mode.switch_rate_state, 2'b00, c.mode.power_level_state});
    rd(b + 8'h01, {2'b00, c.health});
    rd(b + 8'h02, c.modulation_level);
  endtask : rd_chan
  // Verdict and end of run
  task automatic final_report();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report
  // Watchdog
  initial
  begin
    #200000;
    failures++;
    final_report();
  end
  // Main sequence
  initial
  begin
    rows[0] = {3'h5, 2'h2, 6'h2a, 8'hff, 3'h2, 2'h1, 6'h15, 8'h00, 8'h05, 3'h3};
    rows[1] = {3'h2, 2'h1, 6'h15, 8'h01, 3'h5, 2'h2, 6'h2a, 8'hfe, 8'h5a, 3'h4};
    rows[2] = {3'h7, 2'h3, 6'h3f, 8'h80, 3'h7, 2'h3, 6'h3f, 8'h7f, 8'ha0, 3'h7};
    rows[3] = {3'h0, 2'h0, 6'h00, 8'h00, 3'h0, 2'h0, 6'h00, 8'h00, 8'h00, 3'h0};
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    // Reset values
    chk({7'h00, irq}, 8'h00);
    foreach (ro_ofs[i]) rd(ro_ofs[i], 8'h00);
    rd(8'h2d, 8'h30);
    rd(8'h63, 8'h00);
    // Table of input patterns
    foreach (rows[i])
    begin
      @(posedge sys_clk);
      ch0 <= rows[i].c0;
      ch1 <= rows[i].c1;
      err <= rows[i].err;
      cfg <= rows[i].cfg;
      acc = acc | rows[i].err;
      repeat (4) @(posedge sys_clk);
      rd_chan(8'h60, rows[i].c0);
      rd_chan(8'h64, rows[i].c1);
      rd(8'h7c, rows[i].err);
      rd(8'h6d, acc);
      rd(8'h75, {5'h00, rows[i].cfg});
    end
    // Writes to read-only places and repeated reads leave flags alone
    wr(8'h6d, 8'h00);
    wr(8'h7c, 8'hff);
    rd(8'h6d, acc);
    rd(8'h6d, acc);
    rd(8'h7c, 8'h00);
    // Interrupt raise, mask and clear
    wr(8'h80, 8'hff);
    wr(8'h81, 8'h04);
    @(posedge sys_clk);
    err <= 8'h84;
    repeat (4) @(posedge sys_clk);
    chk({7'h00, irq}, 8'h01);
    rd(8'h80, 8'h84);
    @(posedge sys_clk);
    err <= 8'h00;
    wr(8'h80, 8'h04);
    @(posedge sys_clk);
    chk({7'h00, irq}, 8'h00);
    rd(8'h81, 8'h04);
    wr(8'h81, 8'h80);
    @(posedge sys_clk);
    chk({7'h00, irq}, 8'h01);
    wr(8'h80, 8'h80);
    @(posedge sys_clk);
    chk({7'h00, irq}, 8'h00);
    // Wipe: a write keeping bit 2 low does nothing, full toggle clears
    wr(8'h2d, 8'h30);
    rd(8'h6d, acc);
    wr(8'h2d, 8'h34);
    wr(8'h2d, 8'h30);
    @(posedge sys_clk);
    rd(8'h6d, 8'h00);
    rd(8'h2d, 8'h30);
    final_report();
  end
endmodule : amp_status_monitor_regs_tb
